// *** hdl/nvs_cmd_ctrl.v ***
// Command register decoder with save, restore, autosave and sleep control.
// Assumes an external memory engine honours access_allow_out and reports
// completed SRAM writes on sram_write_done_in in this clock domain.
`timescale 1ns/1ps
`include "nvs_cmd_map.vh"

module nvs_cmd_ctrl
#(
  parameter integer   CLK_MHZ     = 100,
  parameter integer   SAVE_NS     = 8000,
  parameter integer   RESTORE_NS  = 20000,
  parameter integer   SETTLE_NS   = 500,
  parameter integer   ENTRY_NS    = 8000,
  parameter integer   WAKE_NS     = 20000,
  parameter [2:0]     DEV_SELECT  = 3'h0,
  parameter integer   TMR_W       = 20
)
(
  input  wire         clk_in,
  input  wire         rst_in,
  input  wire         scl_in,
  input  wire         sda_in,
  output wire         sda_out,
  output wire         sda_oe_out,
  input  wire         write_guard_in,
  input  wire         supply_trip_level_in,
  input  wire         sram_write_done_in,
  output wire         busy_strobe_n_out,
  output wire         busy_strobe_n_oe_out,
  output reg          access_allow_out,
  output reg          write_block_out,
  output reg          autosave_on_out,
  output reg          save_active_out,
  output reg          restore_active_out,
  output reg          doze_out,
  output reg          dirty_out
);

  // -----------------------------------------------------------------------
  // Durations as cycle counts, rounded up
  // -----------------------------------------------------------------------
  localparam integer SAVE_CYC    = (SAVE_NS * CLK_MHZ + 999) / 1000;
  localparam integer RESTORE_CYC = (RESTORE_NS * CLK_MHZ + 999) / 1000;
  localparam integer SETTLE_CYC  = (SETTLE_NS * CLK_MHZ + 999) / 1000;
  localparam integer ENTRY_CYC   = (ENTRY_NS * CLK_MHZ + 999) / 1000;
  localparam integer WAKE_CYC    = (WAKE_NS * CLK_MHZ + 999) / 1000;

  localparam [TMR_W-1:0] SAVE_T    = SAVE_CYC[TMR_W-1:0];
  localparam [TMR_W-1:0] RESTORE_T = RESTORE_CYC[TMR_W-1:0];
  localparam [TMR_W-1:0] SETTLE_T  = SETTLE_CYC[TMR_W-1:0];
  localparam [TMR_W-1:0] ENTRY_T   = ENTRY_CYC[TMR_W-1:0];
  localparam [TMR_W-1:0] WAKE_T    = WAKE_CYC[TMR_W-1:0];
  localparam [TMR_W-1:0] ONE_T     = {{(TMR_W-1){1'b0}}, 1'b1};
  localparam [TMR_W-1:0] ZERO_T    = {TMR_W{1'b0}};

  // -----------------------------------------------------------------------
  // Declarations
  // -----------------------------------------------------------------------
  reg  [1:0]       guard_sync_q;
  reg  [1:0]       trip_sync_q;
  reg  [3:0]       op_q;
  reg  [3:0]       op_d;
  reg  [TMR_W-1:0] tmr_q;
  reg  [TMR_W-1:0] tmr_d;
  reg  [TMR_W-1:0] entry_q;
  reg  [TMR_W-1:0] entry_d;
  reg  [2:0]       fr_q;
  reg  [2:0]       fr_d;
  reg              ack_q;
  reg              ack_d;
  reg              autosave_q;
  reg              autosave_d;
  reg              dirty_q;
  reg              cmd_valid_q;
  reg              cmd_valid_d;
  reg  [7:0]       cmd_q;
  reg  [7:0]       cmd_d;
  reg              wake_req_q;
  reg              wake_req_d;
  reg              nv_done;
  wire             guard_s;
  wire             trip_s;
  wire             rx_start;
  wire             rx_stop;
  wire             rx_valid;
  wire [7:0]       rx_byte;
  wire             tmr_end;
  wire             ready;
  wire             addr_ctrl;
  wire             addr_mem;
  wire             pf_go;

  // -----------------------------------------------------------------------
  // Link receiver
  // -----------------------------------------------------------------------
  nvs_link_rx u_link_rx
  (
    .clk_in         (clk_in),
    .rst_in         (rst_in),
    .scl_in         (scl_in),
    .sda_in         (sda_in),
    .ack_in         (ack_q),
    .start_out      (rx_start),
    .stop_out       (rx_stop),
    .byte_valid_out (rx_valid),
    .byte_out       (rx_byte),
    .sda_out        (sda_out),
    .sda_oe_out     (sda_oe_out)
  );

  // -----------------------------------------------------------------------
  // Pin synchronisers
  // -----------------------------------------------------------------------
  // Reset value low matches the pad pull-down: an open guard pin is inert
  always @(posedge clk_in)
  begin
    if (rst_in)
    begin
      guard_sync_q <= 2'h0;
      trip_sync_q  <= 2'h0;
    end
    else
    begin
      guard_sync_q <= {guard_sync_q[0], write_guard_in};
      trip_sync_q  <= {trip_sync_q[0], supply_trip_level_in};
    end
  end

  assign guard_s = guard_sync_q[1];
  assign trip_s  = trip_sync_q[1];

  // -----------------------------------------------------------------------
  // Address decode
  // -----------------------------------------------------------------------
  assign ready     = (op_q == `NVS_OP_READY);
  assign addr_ctrl = (rx_byte[7:4] == `NVS_CTRL_NIBBLE) &&
                     (rx_byte[3:1] == DEV_SELECT);
  assign addr_mem  = (rx_byte[7:4] == `NVS_MEM_NIBBLE) &&
                     (rx_byte[3:1] == DEV_SELECT);
  assign tmr_end   = (tmr_q == ONE_T);
  assign pf_go     = autosave_q & trip_s;

  // -----------------------------------------------------------------------
  // Frame decoder
  // -----------------------------------------------------------------------
  always @*
  begin
    fr_d        = fr_q;
    ack_d       = ack_q;
    cmd_valid_d = 1'h0;
    cmd_d       = cmd_q;
    wake_req_d  = 1'h0;
    if (rx_start)
    begin
      fr_d  = `NVS_FR_ADDR;
      ack_d = 1'h0;
    end
    else if (rx_stop)
    begin
      fr_d  = `NVS_FR_IDLE;
      ack_d = 1'h0;
    end
    else if (rx_valid)
    begin
      ack_d = 1'h0;
      case (fr_q)
        `NVS_FR_ADDR:
        begin
          fr_d = `NVS_FR_SKIP;
          if ((addr_ctrl || addr_mem) && (op_q == `NVS_OP_DOZE))
            wake_req_d = 1'h1;
          // Busy device leaves the address unanswered; master polls
          if (ready && addr_ctrl && !rx_byte[0])
          begin
            ack_d = 1'h1;
            fr_d  = `NVS_FR_OFFS;
          end
        end
        `NVS_FR_OFFS:
        begin
          fr_d = `NVS_FR_SKIP;
          if (rx_byte == `NVS_CMD_OFFSET)
          begin
            ack_d = 1'h1;
            fr_d  = `NVS_FR_DATA;
          end
        end
        `NVS_FR_DATA:
        begin
          fr_d = `NVS_FR_SKIP;
          // Guarded writes are refused with NACK and leave no trace
          if (!guard_s)
          begin
            ack_d       = 1'h1;
            cmd_valid_d = 1'h1;
            cmd_d       = rx_byte;
          end
        end
        default:
          fr_d = `NVS_FR_SKIP;
      endcase
    end
  end

  always @(posedge clk_in)
  begin
    if (rst_in)
    begin
      fr_q        <= `NVS_FR_IDLE;
      ack_q       <= 1'h0;
      cmd_valid_q <= 1'h0;
      cmd_q       <= `NVS_CELL_RST;
      wake_req_q  <= 1'h0;
    end
    else
    begin
      fr_q        <= fr_d;
      ack_q       <= ack_d;
      cmd_valid_q <= cmd_valid_d;
      cmd_q       <= cmd_d;
      wake_req_q  <= wake_req_d;
    end
  end

  // -----------------------------------------------------------------------
  // Operation sequencer
  // -----------------------------------------------------------------------
  always @*
  begin
    op_d       = op_q;
    tmr_d      = (tmr_q == ZERO_T) ? ZERO_T : tmr_q - ONE_T;
    entry_d    = (entry_q == ZERO_T) ? ZERO_T : entry_q - ONE_T;
    autosave_d = autosave_q;
    nv_done    = 1'h0;
    case (op_q)
      `NVS_OP_BOOT:
      begin
        // Power-up restore has no bypass
        op_d  = `NVS_OP_RESTORE;
        tmr_d = RESTORE_T;
      end
      `NVS_OP_READY:
      begin
        if (pf_go)
        begin
          op_d  = dirty_q ? `NVS_OP_PF_SAVE : `NVS_OP_PF_HALT;
          tmr_d = SAVE_T;
        end
        else if (cmd_valid_q)
        begin
          case (cmd_q)
            `NVS_CODE_SAVE:
            begin
              op_d  = `NVS_OP_SAVE;
              tmr_d = SAVE_T;
            end
            `NVS_CODE_RESTORE:
            begin
              op_d  = `NVS_OP_RESTORE;
              tmr_d = RESTORE_T;
            end
            `NVS_CODE_AS_ON:
            begin
              autosave_d = 1'h1;
              op_d       = `NVS_OP_SETTLE;
              tmr_d      = SETTLE_T;
            end
            `NVS_CODE_AS_OFF:
            begin
              autosave_d = 1'h0;
              op_d       = `NVS_OP_SETTLE;
              tmr_d      = SETTLE_T;
            end
            `NVS_CODE_SLEEP:
            begin
              op_d    = `NVS_OP_SL_SETTLE;
              tmr_d   = SETTLE_T;
              entry_d = ENTRY_T;
            end
            default:
              op_d = `NVS_OP_READY;
          endcase
        end
      end
      `NVS_OP_SAVE,
      `NVS_OP_RESTORE:
      begin
        if (tmr_end)
        begin
          op_d    = `NVS_OP_READY;
          nv_done = 1'h1;
        end
      end
      `NVS_OP_SETTLE:
      begin
        if (tmr_end)
          op_d = `NVS_OP_READY;
      end
      `NVS_OP_SL_SETTLE:
      begin
        if (tmr_end)
        begin
          op_d  = dirty_q ? `NVS_OP_SL_SAVE : `NVS_OP_SL_ENTRY;
          tmr_d = SAVE_T;
        end
      end
      `NVS_OP_SL_SAVE:
      begin
        if (tmr_end)
        begin
          op_d    = `NVS_OP_SL_ENTRY;
          nv_done = 1'h1;
        end
      end
      `NVS_OP_SL_ENTRY:
      begin
        // Entry time counts from the command, not from the save end
        if (entry_q <= ONE_T)
          op_d = `NVS_OP_DOZE;
      end
      `NVS_OP_DOZE:
      begin
        if (pf_go)
        begin
          op_d  = dirty_q ? `NVS_OP_PF_SAVE : `NVS_OP_PF_HALT;
          tmr_d = SAVE_T;
        end
        else if (wake_req_q)
        begin
          op_d  = `NVS_OP_WAKE;
          tmr_d = WAKE_T;
        end
      end
      `NVS_OP_WAKE:
      begin
        if (tmr_end)
          op_d = `NVS_OP_READY;
      end
      `NVS_OP_PF_SAVE:
      begin
        if (tmr_end)
        begin
          op_d    = `NVS_OP_PF_HALT;
          nv_done = 1'h1;
        end
      end
      `NVS_OP_PF_HALT:
      begin
        // Supply came back without a full power cycle: reload the array
        if (!trip_s)
          op_d = `NVS_OP_BOOT;
      end
      default:
        op_d = `NVS_OP_BOOT;
    endcase
  end

  always @(posedge clk_in)
  begin
    if (rst_in)
    begin
      op_q       <= `NVS_OP_BOOT;
      tmr_q      <= ZERO_T;
      entry_q    <= ZERO_T;
      autosave_q <= `NVS_AUTOSAVE_RST;
    end
    else
    begin
      op_q       <= op_d;
      tmr_q      <= tmr_d;
      entry_q    <= entry_d;
      autosave_q <= autosave_d;
    end
  end

  // -----------------------------------------------------------------------
  // Dirty tracking
  // -----------------------------------------------------------------------
  // A write landing with the completion still counts as unsaved
  always @(posedge clk_in)
  begin
    if (rst_in)
      dirty_q <= 1'h0;
    else if (sram_write_done_in)
      dirty_q <= 1'h1;
    else if (nv_done)
      dirty_q <= 1'h0;
  end

  // -----------------------------------------------------------------------
  // Registered status outputs
  // -----------------------------------------------------------------------
  always @(posedge clk_in)
  begin
    if (rst_in)
    begin
      access_allow_out   <= 1'h0;
      write_block_out    <= 1'h0;
      autosave_on_out    <= `NVS_AUTOSAVE_RST;
      save_active_out    <= 1'h0;
      restore_active_out <= 1'h0;
      doze_out           <= 1'h0;
      dirty_out          <= 1'h0;
    end
    else
    begin
      access_allow_out   <= (op_d == `NVS_OP_READY) && !pf_go;
      write_block_out    <= guard_s;
      autosave_on_out    <= autosave_d;
      save_active_out    <= (op_d == `NVS_OP_SAVE) || (op_d == `NVS_OP_SL_SAVE) ||
                            (op_d == `NVS_OP_PF_SAVE);
      restore_active_out <= (op_d == `NVS_OP_RESTORE);
      doze_out           <= (op_d == `NVS_OP_DOZE);
      dirty_out          <= sram_write_done_in | (dirty_q & ~nv_done);
    end
  end

  // Open-drain busy pin: only ever pulls low
  assign busy_strobe_n_out    = 1'h0;
  assign busy_strobe_n_oe_out = save_active_out;

endmodule // nvs_cmd_ctrl

// *** hdl/nvs_cmd_map.vh ***
// Named constants for the nonvolatile command and sleep control block.
// Assumes inclusion by bare name from the design files only.
`ifndef NVS_CMD_MAP_VH
`define NVS_CMD_MAP_VH

// -------------------------------------------------------------------------
// Slave addressing
// -------------------------------------------------------------------------
`define NVS_CTRL_NIBBLE   4'h3
`define NVS_MEM_NIBBLE    4'ha
`define NVS_CMD_OFFSET    8'haa

// -------------------------------------------------------------------------
// Command register codes
// -------------------------------------------------------------------------
`define NVS_CODE_SAVE     8'h3c
`define NVS_CODE_RESTORE  8'h60
`define NVS_CODE_AS_ON    8'h59
`define NVS_CODE_AS_OFF   8'h19
`define NVS_CODE_SLEEP    8'hb9

// -------------------------------------------------------------------------
// Reset values
// -------------------------------------------------------------------------
`define NVS_AUTOSAVE_RST  1'h1
`define NVS_CELL_RST      8'h00

// -------------------------------------------------------------------------
// Link bit counter
// -------------------------------------------------------------------------
`define NVS_BIT_LAST      4'h7
`define NVS_BIT_ACK       4'h8
`define NVS_BIT_DONE      4'h9

// -------------------------------------------------------------------------
// Operation states
// -------------------------------------------------------------------------
`define NVS_OP_BOOT       4'h0
`define NVS_OP_READY      4'h1
`define NVS_OP_SAVE       4'h2
`define NVS_OP_RESTORE    4'h3
`define NVS_OP_SETTLE     4'h4
`define NVS_OP_SL_SETTLE  4'h5
`define NVS_OP_SL_SAVE    4'h6
`define NVS_OP_SL_ENTRY   4'h7
`define NVS_OP_DOZE       4'h8
`define NVS_OP_WAKE       4'h9
`define NVS_OP_PF_SAVE    4'ha
`define NVS_OP_PF_HALT    4'hb

// -------------------------------------------------------------------------
// Frame states
// -------------------------------------------------------------------------
`define NVS_FR_IDLE       3'h0
`define NVS_FR_ADDR       3'h1
`define NVS_FR_OFFS       3'h2
`define NVS_FR_DATA       3'h3
`define NVS_FR_SKIP       3'h4

`endif

// *** hdl/nvs_link_rx.v ***
// Serial link receiver: start/stop detection, byte capture, ACK drive.
// Assumes scl/sda arrive raw from pins; sda is open drain, driven low only.
`timescale 1ns/1ps
`include "nvs_cmd_map.vh"

module nvs_link_rx
(
  input  wire       clk_in,
  input  wire       rst_in,
  input  wire       scl_in,
  input  wire       sda_in,
  input  wire       ack_in,
  output reg        start_out,
  output reg        stop_out,
  output reg        byte_valid_out,
  output reg  [7:0] byte_out,
  output wire       sda_out,
  output wire       sda_oe_out
);

  reg  [1:0] scl_sync_q;
  reg  [1:0] sda_sync_q;
  reg        scl_prev_q;
  reg        sda_prev_q;
  reg  [3:0] bit_cnt_q;
  reg  [7:0] shift_q;
  reg        drive_q;
  wire       scl_s;
  wire       sda_s;
  wire       scl_rise;
  wire       scl_fall;

  // -----------------------------------------------------------------------
  // Pin synchronisers
  // -----------------------------------------------------------------------
  always @(posedge clk_in)
  begin
    if (rst_in)
    begin
      scl_sync_q <= 2'h3;
      sda_sync_q <= 2'h3;
      scl_prev_q <= 1'h1;
      sda_prev_q <= 1'h1;
    end
    else
    begin
      scl_sync_q <= {scl_sync_q[0], scl_in};
      sda_sync_q <= {sda_sync_q[0], sda_in};
      scl_prev_q <= scl_sync_q[1];
      sda_prev_q <= sda_sync_q[1];
    end
  end

  assign scl_s    = scl_sync_q[1];
  assign sda_s    = sda_sync_q[1];
  assign scl_rise = scl_s & ~scl_prev_q;
  assign scl_fall = ~scl_s & scl_prev_q;

  // -----------------------------------------------------------------------
  // Bit engine
  // -----------------------------------------------------------------------
  always @(posedge clk_in)
  begin
    if (rst_in)
    begin
      start_out      <= 1'h0;
      stop_out       <= 1'h0;
      byte_valid_out <= 1'h0;
      byte_out       <= 8'h00;
      bit_cnt_q      <= 4'h0;
      shift_q        <= 8'h00;
      drive_q        <= 1'h0;
    end
    else
    begin
      start_out      <= scl_s & scl_prev_q & ~sda_s & sda_prev_q;
      stop_out       <= scl_s & scl_prev_q & sda_s & ~sda_prev_q;
      byte_valid_out <= 1'h0;
      if (scl_s & scl_prev_q & (sda_s != sda_prev_q))
      begin
        bit_cnt_q <= 4'h0;
        drive_q   <= 1'h0;
      end
      else if (scl_rise)
      begin
        if (bit_cnt_q < `NVS_BIT_ACK)
        begin
          shift_q   <= {shift_q[6:0], sda_s};
          bit_cnt_q <= bit_cnt_q + 4'h1;
          if (bit_cnt_q == `NVS_BIT_LAST)
          begin
            byte_valid_out <= 1'h1;
            byte_out       <= {shift_q[6:0], sda_s};
          end
        end
        else if (bit_cnt_q == `NVS_BIT_ACK)
          bit_cnt_q <= `NVS_BIT_DONE;
      end
      else if (scl_fall)
      begin
        // Ack decision is sampled half a link period after the byte lands
        if (bit_cnt_q == `NVS_BIT_ACK)
          drive_q <= ack_in;
        else if (bit_cnt_q == `NVS_BIT_DONE)
        begin
          drive_q   <= 1'h0;
          bit_cnt_q <= 4'h0;
        end
      end
    end
  end

  assign sda_out    = 1'h0;
  assign sda_oe_out = drive_q;

endmodule // nvs_link_rx

// *** verification/nvs_mst.sv ***
// Master model for the two-wire link: START, bytes with ACK sampling, STOP.
// Assumes the bench resolves the pulled-up data wire and feeds sda_in.
`timescale 1ns/1ps

module nvs_mst
(
  input  wire  clk_in,
  input  wire  sda_in,
  output logic scl_out,
  output logic sda_out
);
  // ----
  // Bit engine, 16 clocks per bit
  // ----
  initial
  begin
    scl_out = 1;
    sda_out = 1;
  end

  task qp;
    repeat (4) @(negedge clk_in);
  endtask

  // Data moves only mid-low, so no false START or STOP is seen
  task bit_x(input logic b, output logic r);
    qp;
    sda_out = b;
    qp;
    scl_out = 1;
    qp;
    r = sda_in;
    qp;
    scl_out = 0;
  endtask

  task frame(input logic [23:0] d, input int n, output logic [2:0] ak);
    logic r;
    ak = 3'h0;
    sda_out = 0;
    qp;
    qp;
    scl_out = 0;
    for (int i = 0; i < n; i++)
    begin
      for (int j = 0; j < 8; j++)
        bit_x(d[23 - 8 * i - j], r);
      bit_x(1'b1, r);
      ak[2 - i] = ~r;
    end
    qp;
    sda_out = 0;
    qp;
    scl_out = 1;
    qp;
    sda_out = 1;
    qp;
    qp;
  endtask
endmodule // nvs_mst

// *** verification/nvs_cmd_chk.sv ***
// Port checker for the command and sleep control block.
// Assumes one clock domain and the synchronous active-high reset.
`timescale 1ns/1ps

module nvs_cmd_chk
(
  input wire clk_in,
  input wire rst_in,
  input wire write_guard_in,
  input wire sram_write_done_in,
  input wire busy_strobe_n_oe_out,
  input wire access_allow_out,
  input wire write_block_out,
  input wire autosave_on_out,
  input wire save_active_out,
  input wire restore_active_out,
  input wire doze_out,
  input wire sda_oe_out,
  input wire sda_out,
  input wire busy_strobe_n_out,
  input wire dirty_out
);
  // ----
  // Properties
  // ----
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);

  property p_busy; save_active_out |-> ##[0:1] busy_strobe_n_oe_out; endproperty
  a_busy: assert property (p_busy) else $error("busy pin idle in save");
  // Open-drain pins may only ever pull low
  property p_odrn; !sda_out && !busy_strobe_n_out; endproperty
  a_odrn: assert property (p_odrn) else $error("open drain driven high");
  property p_svbl; save_active_out && $past(save_active_out) |-> !access_allow_out; endproperty
  a_svbl: assert property (p_svbl) else $error("access open in save");
  property p_rcbl; restore_active_out && $past(restore_active_out) |-> !access_allow_out;
  endproperty
  a_rcbl: assert property (p_rcbl) else $error("access open in restore");
  property p_doze; doze_out |-> !access_allow_out && !sda_oe_out; endproperty
  a_doze: assert property (p_doze) else $error("active while dozing");
  property p_dzcl; $rose(doze_out) |-> !dirty_out; endproperty
  a_dzcl: assert property (p_dzcl) else $error("doze with unsaved data");
  property p_dirty; sram_write_done_in |=> dirty_out; endproperty
  a_dirty: assert property (p_dirty) else $error("write not marked");
  property p_guard; write_guard_in [*4] |=> write_block_out; endproperty
  a_guard: assert property (p_guard) else $error("guard not applied");
  // Reset values must hold even while reset is asserted
  property p_asrst;
    disable iff (1'b0) rst_in |=> autosave_on_out && !dirty_out && !save_active_out;
  endproperty
  a_asrst: assert property (p_asrst) else $error("bad reset state");
  property p_boot; $fell(rst_in) |-> ##[0:3] restore_active_out; endproperty
  a_boot: assert property (p_boot) else $error("no power-up restore");

  c_doze: cover property ($rose(doze_out));
  c_save: cover property ($rose(save_active_out));
  c_asof: cover property ($fell(autosave_on_out));
endmodule // nvs_cmd_chk

bind nvs_cmd_ctrl nvs_cmd_chk u_chk (.clk_in(clk_in), .rst_in(rst_in),
  .write_guard_in(write_guard_in), .sram_write_done_in(sram_write_done_in),
  .busy_strobe_n_oe_out(busy_strobe_n_oe_out), .access_allow_out(access_allow_out),
  .write_block_out(write_block_out), .autosave_on_out(autosave_on_out),
  .save_active_out(save_active_out), .restore_active_out(restore_active_out),
  .doze_out(doze_out), .sda_oe_out(sda_oe_out), .sda_out(sda_out),
  .busy_strobe_n_out(busy_strobe_n_out), .dirty_out(dirty_out));

// *** verification/testbench.sv ***
// Self-checking bench for the command and sleep control block.
// Assumes the master model nvs_mst and the bound checker nvs_cmd_chk.
`timescale 1ns/1ps

module testbench;
  localparam int SV = 40;
  localparam int RC = 60;
  localparam int ST = 10;
  logic       clk_in = 0;
  logic       rst_in = 1;
  logic       guard  = 0;
  logic       trip   = 0;
  logic       wr     = 0;
  logic       scl, m_sda, s_oe, b_oe, acc, wblk, as_on, sv_a, rc_a, doze, dirty;
  wire        sda = m_sda & ~s_oe;
  logic [2:0] ak;
  logic [7:0] c;
  int         n_mismatch = 0, cmp_count = 0, n_sv = 0, n_rc = 0, n_bl = 0, i;

  nvs_mst u_mst (.clk_in(clk_in), .sda_in(sda), .scl_out(scl), .sda_out(m_sda));
  nvs_cmd_ctrl #(.SAVE_NS(400), .RESTORE_NS(600), .SETTLE_NS(100), .ENTRY_NS(800),
    .WAKE_NS(3000)) u_dut (.clk_in(clk_in), .rst_in(rst_in), .scl_in(scl), .sda_in(sda),
    .sda_out(), .sda_oe_out(s_oe), .write_guard_in(guard), .supply_trip_level_in(trip),
    .sram_write_done_in(wr), .busy_strobe_n_out(), .busy_strobe_n_oe_out(b_oe),
    .access_allow_out(acc), .write_block_out(wblk), .autosave_on_out(as_on),
    .save_active_out(sv_a), .restore_active_out(rc_a), .doze_out(doze), .dirty_out(dirty));

  initial
  begin
    forever #5 clk_in = ~clk_in;
  end

  // Counters, since operations start before a frame's STOP returns
  always @(posedge clk_in)
  begin
    n_sv <= n_sv + int'(sv_a === 1'b1);
    n_rc <= n_rc + int'(rc_a === 1'b1);
    n_bl <= n_bl + int'(acc === 1'b0);
  end

  // ----
  // Helpers
  // ----
  task end_sim;
    $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task chk(input logic ok, input string m);
    cmp_count++;
    if (ok !== 1'b1)
    begin
      n_mismatch++;
      $display("BAD %0t %s", $time, m);
    end
  endtask

  function logic sg(int w);
    case (w)
      0: return acc;
      1: return sv_a;
      2: return rc_a;
      default: return doze;
    endcase
  endfunction

  task wt(input int w, input logic v, input int lim);
    int k;
    for (k = 0; k < lim && sg(w) !== v; k++)
      @(negedge clk_in);
    if (k == lim)
    begin
      n_mismatch++;
      $display("BAD %0t wait %0d", $time, w);
      end_sim;
    end
  endtask

  function logic known(logic [7:0] x);
    return x inside {8'h3c, 8'h60, 8'h59, 8'h19, 8'hb9};
  endfunction

  task clr;
    n_sv = 0;
    n_rc = 0;
    n_bl = 0;
  endtask

  task cmd(input logic [7:0] x);
    clr;
    u_mst.frame({8'h30, 8'haa, x}, 3, ak);
    chk(ak === {2'b11, ~guard}, "ack");
    wt(0, 1'b1, 200);
  endtask

  task wpulse;
    wr = 1;
    @(negedge clk_in);
    wr = 0;
    chk(dirty === 1'b1, "dirty");
  endtask

  // Wake time spans more than one poll, so at least one poll must be refused
  task wake(input logic [7:0] a);
    u_mst.frame({a, 16'h0}, 1, ak);
    chk(ak[2] === 1'b0, "wake nack");
    for (i = 0; i < 20 && ak[2] !== 1'b1; i++)
      u_mst.frame({8'h30, 16'h0}, 1, ak);
    if (ak[2] !== 1'b1)
    begin
      n_mismatch++;
      $display("BAD %0t wake poll", $time);
      end_sim;
    end
    chk(ak[2] === 1'b1 && doze === 1'b0 && i > 1, "wake");
  endtask

  initial
  begin
    #500000;
    n_mismatch++;
    end_sim;
  end

  // ----
  // Scenarios
  // ----
  initial
  begin
    i = $urandom(32'hdd88);
    repeat (5) @(negedge clk_in);
    rst_in = 0;
    wt(0, 1'b1, 200);
    chk(n_rc == RC && as_on === 1'b1 && dirty === 1'b0, "boot");
    cmd(8'h3c);
    chk(n_sv == SV && dirty === 1'b0, "clean save");
    wpulse;
    cmd(8'h60);
    chk(n_rc == RC && n_sv == 0 && dirty === 1'b0, "restore");
    clr;
    u_mst.frame({8'h30, 8'h55, 8'h3c}, 3, ak);
    chk(ak === 3'b100 && n_sv == 0, "bad offset");
    $display("save restore done");
    cmd(8'h19);
    chk(as_on === 1'b0 && n_bl >= ST && n_bl <= ST + 3, "as off");
    cmd(8'h59);
    chk(as_on === 1'b1 && n_bl >= ST && n_bl <= ST + 3, "as on");
    repeat (6)
    begin
      c = 8'($urandom);
      while (known(c))
        c = 8'($urandom);
      cmd(c);
      chk(n_sv + n_rc + n_bl == 0 && as_on === 1'b1, "unknown");
    end
    guard = 1;
    cmd(8'h3c);
    chk(wblk === 1'b1 && n_sv == 0, "guard");
    guard = 0;
    $display("command decode done");
    clr;
    u_mst.frame({8'h30, 8'haa, 8'hb9}, 3, ak);
    wt(3, 1'b1, 200);
    chk(n_sv == 0 && acc === 1'b0 && wblk === 1'b0, "sleep clean");
    wake(8'ha0);
    wpulse;
    clr;
    u_mst.frame({8'h30, 8'haa, 8'hb9}, 3, ak);
    wt(3, 1'b1, 200);
    chk(n_sv == SV && dirty === 1'b0, "sleep save");
    wake(8'h30);
    $display("sleep done");
    wpulse;
    clr;
    trip = 1;
    wt(1, 1'b1, 30);
    chk(acc === 1'b0, "pf block");
    wt(1, 1'b0, 100);
    chk(n_sv == SV && acc === 1'b0, "pf save");
    trip = 0;
    wt(0, 1'b1, 200);
    clr;
    trip = 1;
    repeat (20) @(negedge clk_in);
    chk(n_sv == 0, "pf clean");
    trip = 0;
    wt(0, 1'b1, 200);
    $display("power fail done");
    end_sim;
  end
endmodule // testbench
